/* hw/strap_mode_config_loader.sv */
// start-up strap sampler producing the stand-alone control register values
//
// Contract
// - straps sampled once right after reset release; captured levels form configuration
// - board pulls every strap, phase update optionally; only phase update strap has internal pull-down
// - output data strap low selects hardware operation; straps override fields
// - port role strap low gives slave port, high gives master port
// - format code high bit from audio strap, low bit from status strap
// - code 00 clears format bits; 01 sets delay and frame polarity only
// - code 10 sets justify only; 11 sets resolution 11; bitclock rate zero
// - user bit strap low gives 256x recovered clock, high gives 128x
// - phase update strap low normal rate, high higher detector update rate
// - deemphasis strap drives setting bit 2; bits 1 and 0 forced 00
// - error policy strap sets validity mask; fixed masks set, check masks clear
// - automatic clock switch set by any system clock transition after reset
// - hardware operation forces fixed control bits; low select bits follow pins
// - offsets 07h to 7Fh get no strap derived values
// - invalid-or-error holding repeats on validity or errors; error-only on errors
// - status and user bits shift on both frame clock edges, master only
`timescale 1ns/1ps
`default_nettype none
module strap_mode_config_loader
    import strap_pkg::*;
(
    input  wire logic       REF_CLK,              // 125 MHz device clock
    input  wire logic       RESET,                // synchronous reset, high
    input  wire logic       OUTPUT_DATA_STRAP,    // low: hardware operation
    input  wire logic       PORT_ROLE_STRAP,      // serial port role strap
    input  wire logic       AUDIO_STRAP,          // format select high bit
    input  wire logic       STATUS_STRAP,         // format select low bit
    input  wire logic       USER_BIT_STRAP,       // recovered clock ratio strap
    input  wire logic       PHASE_UPDATE_STRAP,   // internally pulled down
    input  wire logic       DEEMPHASIS_STRAP,     // auto emphasis match strap
    input  wire logic       ERROR_POLICY_STRAP,   // hold policy strap
    input  wire logic       SYSTEM_MASTER_CLOCK,  // sampled for activity only
    input  wire logic [1:0] RX_SELECT_PINS,       // receiver input select
    input  wire logic [1:0] TX_SELECT_PINS,       // pass-through select
    input  wire logic [6:0] REG_ADDR,             // register offset looked up
    output logic      [7:0] REG_DATA,             // forced value at REG_ADDR
    output logic            REG_FORCED,           // REG_ADDR holds a forced value
    output logic            HARDWARE_MODE,        // straps in control
    output logic            CONFIG_VALID,         // straps captured
    output logic            STATUS_SHIFT_ENABLE,  // status/user shift on frame edges
    output logic            ERROR_OR_INVALID_HOLD,// holding includes validity
    output logic            ERROR_ONLY_HOLD,      // holding on errors only
    output forced_regs_s    FORCED_REGS           // all seven forced bytes
);
    localparam int NUM_STRAPS = $bits(strap_s);

    load_state_e  state;
    load_state_e  next_state;
    strap_s       strap_pins;
    strap_s       strap_sync;
    strap_s       captured;
    logic [1:0]   rx_sync;
    logic [1:0]   tx_sync;
    logic         sysclk_sync;
    logic         clock_seen;
    forced_regs_s next_regs;

    assign strap_pins = '{
        output_data_strap:  OUTPUT_DATA_STRAP,
        port_role_strap:    PORT_ROLE_STRAP,
        format_select_high: AUDIO_STRAP,
        format_select_low:  STATUS_STRAP,
        user_bit_strap:     USER_BIT_STRAP,
        phase_update_strap: PHASE_UPDATE_STRAP,
        deemphasis_strap:   DEEMPHASIS_STRAP,
        error_policy_strap: ERROR_POLICY_STRAP
    };

    pin_sync #(.WIDTH(NUM_STRAPS)) u_strap_sync (
        .clk      (REF_CLK),
        .rst      (RESET),
        .async_in (strap_pins),
        .sync_out (strap_sync)
    );

    pin_sync #(.WIDTH(5)) u_misc_sync (
        .clk      (REF_CLK),
        .rst      (RESET),
        .async_in ({SYSTEM_MASTER_CLOCK, RX_SELECT_PINS, TX_SELECT_PINS}),
        .sync_out ({sysclk_sync, rx_sync, tx_sync})
    );

    clock_activity u_clock_activity (
        .clk   (REF_CLK),
        .rst   (RESET),
        .level (sysclk_sync),
        .seen  (clock_seen)
    );

    // the synchroniser needs two edges after release before the pins are valid,
    // so sampling waits in ST_SAMPLE for that pipeline to fill
    logic [1:0] fill_count;
    wire        fill_done = (fill_count == 2'(SYNC_STAGES));

    always_comb begin
        next_state = state;
        case (state)
            ST_RESET:  next_state = ST_SAMPLE;
            ST_SAMPLE: if (fill_done) next_state = ST_HOLD;
            ST_HOLD:   next_state = ST_HOLD;
            default:   next_state = ST_RESET;
        endcase
    end

    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            state      <= ST_RESET;
            fill_count <= 2'h0;
        end else begin
            state      <= next_state;
            fill_count <= (state == ST_SAMPLE && !fill_done) ? fill_count + 2'h1 : fill_count;
        end
    end

    // captured once; never reloaded until reset returns
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            captured <= '0;
        end else if (state == ST_SAMPLE && fill_done) begin
            captured <= strap_sync;
        end
    end

    wire       valid_now = (state == ST_HOLD);
    wire       hw_mode   = valid_now && !captured.output_data_strap;
    wire [1:0] fmt_code  = {captured.format_select_high,
                            captured.format_select_low};

    logic [7:0] fmt_bits;
    always_comb begin
        fmt_bits = RESET_BYTE;                                // rate stays zero
        fmt_bits[POS_PORT_MASTER_SELECT] = captured.port_role_strap;
        case (fmt_code)
            FMT_LEFT_JUST: ;
            FMT_I2S: begin
                fmt_bits[POS_DELAY_SELECT]        = 1'b1;
                fmt_bits[POS_FRAMECLOCK_POLARITY] = 1'b1;
            end
            FMT_RIGHT_JUST: fmt_bits[POS_JUSTIFY_SELECT] = 1'b1;
            FMT_DIRECT: fmt_bits[POS_OUTPUT_RES_LO +: 2] = RES_DIRECT;
            default: ;
        endcase
    end

    always_comb begin
        next_regs = '0;
        next_regs.control_zero[POS_FORCED_CLOCK_SWITCH] = 1'b0;
        next_regs.control_zero[POS_PHASE_UPDATE_RATE] =
            captured.phase_update_strap;
        next_regs.control_zero[POS_LENGTH_CUT]        = 1'b0;
        next_regs.control_one[POS_AUTO_CLOCK_SWITCH]  = clock_seen;
        next_regs.control_one[POS_OUTPUT_MUTE]        = 1'b0;
        next_regs.control_one[POS_HOLD_LO +: 2]       = 2'h0;
        next_regs.control_one[POS_RECOVERED_RATIO]    = captured.user_bit_strap;
        next_regs.control_one[POS_CHANNEL_PICK]       = 1'b0;
        next_regs.control_two[POS_DEEMPH_HI]          = captured.deemphasis_strap;
        next_regs.control_two[POS_DEEMPH_LO +: 2]     = 2'h0;
        next_regs.control_four[POS_RUN]               = 1'b1;
        next_regs.control_four[POS_RECEIVER_DISABLE]  = 1'b0;
        next_regs.control_four[POS_RX_SELECT_LO +: 2] = rx_sync;
        next_regs.control_four[POS_TX_SELECT_LO +: 2] = tx_sync;
        next_regs.output_port_format                  = fmt_bits;
        next_regs.receive_error_mask[POS_QCODE_CHECK_MASK]  = 1'b0;
        next_regs.receive_error_mask[POS_STATUS_CHECK_MASK] = 1'b0;
        next_regs.receive_error_mask[POS_LOCK_LOSS_MASK]    = 1'b1;
        next_regs.receive_error_mask[POS_CONFIDENCE_MASK]   = 1'b1;
        next_regs.receive_error_mask[POS_BIPHASE_MASK]      = 1'b1;
        next_regs.receive_error_mask[POS_PARITY_MASK]       = 1'b1;
        next_regs.receive_error_mask[POS_VALIDITY_MASK]     =
            captured.error_policy_strap;
    end

    // forced bytes register only in hardware operation; software mode leaves
    // the register file to the control port, so these read back as zero
    forced_regs_s regs_q;
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            regs_q <= '0;
        end else begin
            regs_q <= hw_mode ? next_regs : '0;
        end
    end
    assign FORCED_REGS = regs_q;

    // offset lookup; above the forced range nothing is driven from straps
    wire addr_forced = hw_mode && (REG_ADDR <= OFS_LAST_FORCED);
    logic [7:0] addr_byte;
    always_comb begin
        case (REG_ADDR)
            OFS_CONTROL_ZERO:     addr_byte = regs_q.control_zero;
            OFS_CONTROL_ONE:      addr_byte = regs_q.control_one;
            OFS_CONTROL_TWO:      addr_byte = regs_q.control_two;
            OFS_CONTROL_THREE:    addr_byte = regs_q.control_three;
            OFS_CONTROL_FOUR:     addr_byte = regs_q.control_four;
            OFS_OUTPUT_PORT_FMT:  addr_byte = regs_q.output_port_format;
            OFS_RECEIVE_ERR_MASK: addr_byte = regs_q.receive_error_mask;
            default:              addr_byte = RESET_BYTE;
        endcase
    end

    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            REG_DATA              <= RESET_BYTE;
            REG_FORCED            <= 1'b0;
            HARDWARE_MODE         <= 1'b0;
            CONFIG_VALID          <= 1'b0;
            STATUS_SHIFT_ENABLE   <= 1'b0;
            ERROR_OR_INVALID_HOLD <= 1'b0;
            ERROR_ONLY_HOLD       <= 1'b0;
        end else begin
            REG_DATA              <= addr_forced ? addr_byte : RESET_BYTE;
            REG_FORCED            <= addr_forced;
            HARDWARE_MODE         <= hw_mode;
            CONFIG_VALID          <= valid_now;
            // shifting uses both frame clock edges; the port must be master
            STATUS_SHIFT_ENABLE   <= hw_mode && captured.port_role_strap;
            ERROR_OR_INVALID_HOLD <= hw_mode && captured.error_policy_strap;
            ERROR_ONLY_HOLD       <= hw_mode && !captured.error_policy_strap;
        end
    end
endmodule : strap_mode_config_loader
`default_nettype wire

/* hw/strap_pkg.sv */
// shared constants and carriers for the start-up strap configuration loader
package strap_pkg;

    // register offsets of the forced control bytes
    localparam logic [6:0] OFS_CONTROL_ZERO      = 7'h00;
    localparam logic [6:0] OFS_CONTROL_ONE       = 7'h01;
    localparam logic [6:0] OFS_CONTROL_TWO       = 7'h02;
    localparam logic [6:0] OFS_CONTROL_THREE     = 7'h03;
    localparam logic [6:0] OFS_CONTROL_FOUR      = 7'h04;
    localparam logic [6:0] OFS_OUTPUT_PORT_FMT   = 7'h05;
    localparam logic [6:0] OFS_RECEIVE_ERR_MASK  = 7'h06;
    localparam logic [6:0] OFS_LAST_FORCED       = 7'h06;
    localparam logic [6:0] OFS_TOP               = 7'h7f;

    // control_zero fields
    localparam int POS_FORCED_CLOCK_SWITCH = 6;
    localparam int POS_PHASE_UPDATE_RATE   = 3;
    localparam int POS_LENGTH_CUT          = 2;
    // control_one fields
    localparam int POS_AUTO_CLOCK_SWITCH   = 7;
    localparam int POS_OUTPUT_MUTE         = 6;
    localparam int POS_HOLD_LO             = 2;
    localparam int POS_RECOVERED_RATIO     = 1;
    localparam int POS_CHANNEL_PICK        = 0;
    // control_two fields
    localparam int POS_DEEMPH_HI           = 6;
    localparam int POS_DEEMPH_LO           = 4;
    // control_four fields
    localparam int POS_RUN                 = 7;
    localparam int POS_RECEIVER_DISABLE    = 6;
    localparam int POS_RX_SELECT_LO        = 3;
    localparam int POS_TX_SELECT_LO        = 0;
    // output_port_format fields
    localparam int POS_PORT_MASTER_SELECT  = 7;
    localparam int POS_BITCLOCK_RATE       = 6;
    localparam int POS_OUTPUT_RES_LO       = 4;
    localparam int POS_JUSTIFY_SELECT      = 3;
    localparam int POS_DELAY_SELECT        = 2;
    localparam int POS_BITCLOCK_POLARITY   = 1;
    localparam int POS_FRAMECLOCK_POLARITY = 0;
    // receive_error_mask fields
    localparam int POS_QCODE_CHECK_MASK    = 6;
    localparam int POS_STATUS_CHECK_MASK   = 5;
    localparam int POS_LOCK_LOSS_MASK      = 4;
    localparam int POS_CONFIDENCE_MASK     = 3;
    localparam int POS_BIPHASE_MASK        = 2;
    localparam int POS_PARITY_MASK         = 1;
    localparam int POS_VALIDITY_MASK       = 0;

    // reset value of every forced byte before straps are taken
    localparam logic [7:0] RESET_BYTE      = 8'h00;
    // synchroniser depth for pins
    localparam int SYNC_STAGES             = 2;

    // serial format codes
    localparam logic [1:0] FMT_LEFT_JUST   = 2'h0;
    localparam logic [1:0] FMT_I2S         = 2'h1;
    localparam logic [1:0] FMT_RIGHT_JUST  = 2'h2;
    localparam logic [1:0] FMT_DIRECT      = 2'h3;
    localparam logic [1:0] RES_DIRECT      = 2'h3;

    // captured straps, one bit per pin
    typedef struct packed {
        logic output_data_strap;
        logic port_role_strap;
        logic format_select_high;
        logic format_select_low;
        logic user_bit_strap;
        logic phase_update_strap;
        logic deemphasis_strap;
        logic error_policy_strap;
    } strap_s;

    // the seven forced control bytes
    typedef struct packed {
        logic [7:0] control_zero;
        logic [7:0] control_one;
        logic [7:0] control_two;
        logic [7:0] control_three;
        logic [7:0] control_four;
        logic [7:0] output_port_format;
        logic [7:0] receive_error_mask;
    } forced_regs_s;

    typedef enum logic [1:0] {
        ST_RESET,
        ST_SAMPLE,
        ST_HOLD
    } load_state_e;

endpackage : strap_pkg

/* hw/pin_sync.sv */
// two-flop synchroniser for a group of asynchronous pins
`timescale 1ns/1ps
`default_nettype none
module pin_sync
    import strap_pkg::*;
#(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,       // device clock
    input  wire logic             rst,       // synchronous reset, high
    input  wire logic [WIDTH-1:0] async_in,  // raw pin levels
    output logic      [WIDTH-1:0] sync_out   // levels in the clock domain
);
    logic [WIDTH-1:0] stage_one;

    // stage_one is read only by sync_out
    always_ff @(posedge clk) begin
        if (rst) begin
            stage_one <= '0;
            sync_out  <= '0;
        end else begin
            stage_one <= async_in;
            sync_out  <= stage_one;
        end
    end
endmodule : pin_sync
`default_nettype wire

/* hw/clock_activity.sv */
// detects any transition on a sampled clock pin after reset
`timescale 1ns/1ps
`default_nettype none
module clock_activity
    import strap_pkg::*;
(
    input  wire logic clk,        // device clock
    input  wire logic rst,        // synchronous reset, high
    input  wire logic level,      // synchronised clock pin level
    output logic      seen        // sticky: a transition was observed
);
    logic       last_level;
    logic [1:0] warm;
    wire        primed   = (warm == 2'(SYNC_STAGES + 1));
    wire        edge_now = primed && (level != last_level);

    // edges count only once the synchroniser's reset zeros have drained,
    // else a pin idling high would look like a toggle right after reset
    always_ff @(posedge clk) begin
        if (rst) begin
            last_level <= 1'b0;
            warm       <= 2'h0;
            seen       <= 1'b0;
        end else begin
            last_level <= level;
            warm       <= primed ? warm : warm + 2'h1;
            seen       <= seen | edge_now;
        end
    end
endmodule : clock_activity
`default_nettype wire

/* bench/strap_loader_asserts.sv */
// concurrent checks on the strap loader outputs, bound to its top module
`timescale 1ns/1ps
`default_nettype none
module strap_loader_asserts
    import strap_pkg::*;
(
    input wire logic         REF_CLK,               // device clock
    input wire logic         RESET,                 // synchronous reset, high
    input wire logic   [6:0] REG_ADDR,              // lookup offset
    input wire logic   [7:0] REG_DATA,              // looked-up byte
    input wire logic         REG_FORCED,            // offset holds a forced byte
    input wire logic         HARDWARE_MODE,         // straps in control
    input wire logic         CONFIG_VALID,          // straps captured
    input wire logic         STATUS_SHIFT_ENABLE,   // status shift allowed
    input wire logic         ERROR_OR_INVALID_HOLD, // validity also holds
    input wire logic         ERROR_ONLY_HOLD,       // errors only hold
    input wire forced_regs_s FORCED_REGS            // the forced bytes
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (RESET);

    // two cycles of hardware mode let every output stage catch up
    sequence settled_s;
        HARDWARE_MODE && $past(HARDWARE_MODE, 2);
    endsequence
    sequence high_addr_s;
        !$past(RESET) && ($past(REG_ADDR) > OFS_LAST_FORCED);
    endsequence
    sequence fmt_addr_s;
        $past(HARDWARE_MODE) && ($past(REG_ADDR) == OFS_OUTPUT_PORT_FMT);
    endsequence

    capture_window_a: assert property ($fell(RESET) |-> !CONFIG_VALID[*2] ##[1:6] CONFIG_VALID)
        else $error("straps not captured in time after reset release");
    captured_stable_a: assert property (CONFIG_VALID && $past(CONFIG_VALID, 2) |->
        $stable(FORCED_REGS.output_port_format) && $stable(FORCED_REGS.receive_error_mask)
        && $stable(HARDWARE_MODE))
        else $error("captured configuration moved without reset");
    software_zero_a: assert property (!HARDWARE_MODE |-> FORCED_REGS == '0)
        else $error("forced bytes nonzero outside hardware mode");
    format_table_a: assert property (settled_s |->
        FORCED_REGS.output_port_format[6:0] inside {7'h00, 7'h05, 7'h08, 7'h30})
        else $error("format bits outside the four codes");
    mask_fixed_a: assert property (settled_s |-> FORCED_REGS.receive_error_mask[7:1] == 7'h0f)
        else $error("fixed error masks wrong");
    hold_policy_a: assert property (settled_s |-> (ERROR_OR_INVALID_HOLD != ERROR_ONLY_HOLD)
        && (ERROR_OR_INVALID_HOLD == FORCED_REGS.receive_error_mask[0]))
        else $error("hold policy disagrees with validity mask");
    shift_master_a: assert property (settled_s |->
        STATUS_SHIFT_ENABLE == FORCED_REGS.output_port_format[7])
        else $error("status shift enable not tied to master role");
    fixed_bits_a: assert property (settled_s |-> ((FORCED_REGS.control_zero & 8'hf7) == 8'h00)
        && ((FORCED_REGS.control_one & 8'h7d) == 8'h00) && ((FORCED_REGS.control_two & 8'hbf) == 8'h00)
        && (FORCED_REGS.control_three == 8'h00) && (FORCED_REGS.control_four[7:5] == 3'h4)
        && !FORCED_REGS.control_four[2])
        else $error("fixed control bits wrong");
    high_offset_a: assert property (high_addr_s |-> REG_DATA == 8'h00 && !REG_FORCED)
        else $error("offset above forced range returned data");
    format_read_a: assert property (settled_s and fmt_addr_s |->
        REG_FORCED && REG_DATA == FORCED_REGS.output_port_format)
        else $error("format read differs from forced byte");
endmodule : strap_loader_asserts

bind strap_mode_config_loader strap_loader_asserts strap_loader_asserts_inst (
    .REF_CLK(REF_CLK), .RESET(RESET), .REG_ADDR(REG_ADDR), .REG_DATA(REG_DATA),
    .REG_FORCED(REG_FORCED), .HARDWARE_MODE(HARDWARE_MODE), .CONFIG_VALID(CONFIG_VALID),
    .STATUS_SHIFT_ENABLE(STATUS_SHIFT_ENABLE), .ERROR_OR_INVALID_HOLD(ERROR_OR_INVALID_HOLD),
    .ERROR_ONLY_HOLD(ERROR_ONLY_HOLD), .FORCED_REGS(FORCED_REGS)
);
`default_nettype wire

/* bench/board_straps.sv */
// board pull resistors seen by the strap pins
`timescale 1ns/1ps
`default_nettype none
module board_straps
    import strap_pkg::*;
(
    input  wire strap_s pull,         // level each fitted resistor pulls to
    input  wire logic   phase_fitted, // resistor present on the phase update pin
    output var  strap_s pins          // levels at the device pins
);
    // every strap but the phase pin always has a resistor, so it never floats
    assign pins.output_data_strap  = pull.output_data_strap;
    assign pins.port_role_strap    = pull.port_role_strap;
    assign pins.format_select_high = pull.format_select_high;
    assign pins.format_select_low  = pull.format_select_low;
    assign pins.user_bit_strap     = pull.user_bit_strap;
    assign pins.deemphasis_strap   = pull.deemphasis_strap;
    assign pins.error_policy_strap = pull.error_policy_strap;
    // left open, the internal pull-down wins
    assign pins.phase_update_strap = phase_fitted & pull.phase_update_strap;
endmodule : board_straps
`default_nettype wire

/* bench/test_strap_mode_config_loader.sv */
// self-checking bench for the strap configuration loader
`timescale 1ns/1ps
`default_nettype none
module test_strap_mode_config_loader;
    import strap_pkg::*;
    logic         ref_clk, reset, phase_fitted, sys_clk, reg_forced, hw_mode;
    logic         cfg_valid, shift_en, hold_any, hold_err;
    logic   [1:0] rx_pins, tx_pins;
    logic   [6:0] reg_addr;
    logic   [7:0] reg_data;
    strap_s       pull, pins;
    forced_regs_s forced;
    int           mismatches, checks;

    board_straps board_straps_inst (.pull(pull), .phase_fitted(phase_fitted), .pins(pins));
    strap_mode_config_loader strap_mode_config_loader_inst (
        .REF_CLK(ref_clk), .RESET(reset), .OUTPUT_DATA_STRAP(pins.output_data_strap),
        .PORT_ROLE_STRAP(pins.port_role_strap), .AUDIO_STRAP(pins.format_select_high),
        .STATUS_STRAP(pins.format_select_low), .USER_BIT_STRAP(pins.user_bit_strap),
        .PHASE_UPDATE_STRAP(pins.phase_update_strap), .DEEMPHASIS_STRAP(pins.deemphasis_strap),
        .ERROR_POLICY_STRAP(pins.error_policy_strap), .SYSTEM_MASTER_CLOCK(sys_clk),
        .RX_SELECT_PINS(rx_pins), .TX_SELECT_PINS(tx_pins), .REG_ADDR(reg_addr),
        .REG_DATA(reg_data), .REG_FORCED(reg_forced), .HARDWARE_MODE(hw_mode),
        .CONFIG_VALID(cfg_valid), .STATUS_SHIFT_ENABLE(shift_en),
        .ERROR_OR_INVALID_HOLD(hold_any), .ERROR_ONLY_HOLD(hold_err), .FORCED_REGS(forced)
    );

    initial begin
        ref_clk = 1'h0;
        forever #4 ref_clk = ~ref_clk;
    end

    task automatic chk(input logic [55:0] seen, input logic [55:0] want);
        checks++;
        if (seen !== want) begin
            mismatches++;
            $display("BAD at %0t: saw %h expected %h", $time, seen, want);
        end
    endtask : chk

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : give_verdict

    // expected forced bytes worked out from the captured levels
    function automatic forced_regs_s model(input strap_s s, input logic seen,
                                           input logic [1:0] rx, input logic [1:0] tx);
        forced_regs_s r;
        r = '0;
        if (!s.output_data_strap) begin
            r.control_zero = {4'h0, s.phase_update_strap, 3'h0};
            r.control_one = {seen, 5'h00, s.user_bit_strap, 1'h0};
            r.control_two = {1'h0, s.deemphasis_strap, 6'h00};
            r.control_four = {3'h4, rx, 1'h0, tx};
            case ({s.format_select_high, s.format_select_low})
                2'h1: r.output_port_format = 8'h05;
                2'h2: r.output_port_format = 8'h08;
                2'h3: r.output_port_format = 8'h30;
                default: r.output_port_format = 8'h00;
            endcase
            r.output_port_format[7] = s.port_role_strap;
            r.receive_error_mask = {7'h0f, s.error_policy_strap};
        end
        return r;
    endfunction : model

    task automatic read_reg(input logic [6:0] a, input logic [7:0] want, input logic f);
        reg_addr = a;
        @(negedge ref_clk);
        chk({48'h0, reg_data}, {48'h0, want});
        chk({55'h0, reg_forced}, {55'h0, f});
    endtask : read_reg

    task automatic run(input strap_s s, input logic fit, input logic tog);
        strap_s       eff;
        logic         hw;
        forced_regs_s e;
        eff = s;
        eff.phase_update_strap = fit & s.phase_update_strap;
        hw = !s.output_data_strap;
        pull = s;
        phase_fitted = fit;
        reset = 1'h1;
        repeat (2) @(negedge ref_clk);
        reset = 1'h0;
        repeat (10) @(negedge ref_clk);
        chk({55'h0, cfg_valid}, 56'h1);
        chk({55'h0, hw_mode}, {55'h0, hw});
        chk(forced, model(eff, 1'h0, rx_pins, tx_pins));
        // toggles start only after capture, so no edge falls in the clock_activity warm-up before it is primed
        repeat (tog ? 4 : 0) begin
            sys_clk = ~sys_clk;
            @(negedge ref_clk);
        end
        // late strap moves must be ignored while the select pins stay live
        pull = ~s;
        rx_pins = ~rx_pins;
        tx_pins = ~tx_pins;
        repeat (8) @(negedge ref_clk);
        e = model(eff, tog, rx_pins, tx_pins);
        chk(forced, e);
        chk({55'h0, shift_en}, {55'h0, hw & s.port_role_strap});
        chk({54'h0, hold_any, hold_err},
            {54'h0, hw & s.error_policy_strap, hw & ~s.error_policy_strap});
        for (int a = 0; a < 7; a++)
            read_reg(7'(a), e[55-8*a -: 8], hw);
        read_reg(7'h07, 8'h00, 1'h0);
        read_reg(7'h7f, 8'h00, 1'h0);
    endtask : run

    initial begin
        reset = 1'h1;
        pull = '0;
        phase_fitted = 1'h1;
        sys_clk = 1'h0;
        rx_pins = 2'h0;
        tx_pins = 2'h0;
        reg_addr = 7'h00;
        mismatches = 0;
        checks = 0;
        repeat (6) @(negedge ref_clk);
        for (int i = 0; i < 9; i++) begin
            rx_pins = i[1:0];
            tx_pins = ~i[1:0];
            // a clock pin idling high through reset must not count as a toggle
            sys_clk = i[1];
            run({i[3], i[2], i[1], i[0], i[0] ^ i[1], i[2], i[1], ~i[0]}, i != 5, i[0]);
        end
        give_verdict();
    end

    // nine runs need about 280 cycles; this leaves ample room
    initial begin
        #(8 * 5000);
        mismatches++;
        give_verdict();
    end
endmodule : test_strap_mode_config_loader
`default_nettype wire
